// ---- core/gac_regs.sv ----
// Purpose: aperture base, capability pointer and system config registers
// Assumes: one request pulse at a time; size control comes from elsewhere
// Notes: answer and read data appear one clock after the request
`timescale 1ns/1ps
module gac_regs
	import gac_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// configuration request
	input wire gac_req_t cfg_req,
	// configuration answer
	output logic [31:0] cfg_rdata_reg,
	output logic cfg_done_reg,
	// size control from the back-end size register
	input wire logic [5:0] aperture_size_control,
	// decoded state for the rest of the bridge
	output logic [31:0] aperture_base_address_reg,
	output logic interrupt_write_handshake_disable_reg
);
	gac_state_t state_reg;
	gac_state_t state_next;
	logic [31:0] read_word;
	logic [31:0] write_mask;
	logic [31:0] merged_word;
	logic [5:0] sized_visible;

	// a sized bit is visible only while its size bit allows it
	assign sized_visible = state_reg.base_sized & aperture_size_control;

	// read mux; unmapped dwords read zero
	always_comb begin
		read_word = 32'h0000_0000;
		write_mask = 32'h0000_0000;
		unique case (cfg_req.addr)
			GAC_OFS_APERTURE_BASE: begin
				read_word = {state_reg.base_upper, sized_visible,
					GAC_APERTURE_LOW_FIXED};
				write_mask = GAC_UPPER_WMASK |
					(32'({aperture_size_control}) << GAC_BASE_SIZED_LSB);
			end
			GAC_OFS_CAP_POINTER: begin
				read_word = {24'h00_0000, GAC_CAP_POINTER_VALUE};
			end
			GAC_OFS_SYSTEM_CONFIG: begin
				read_word = {16'h0000, state_reg.handshake_disable,
					15'h0000};
				write_mask = GAC_CONFIG_WMASK;
			end
			default: begin
				read_word = 32'h0000_0000;
				write_mask = 32'h0000_0000;
			end
		endcase
	end

	// byte lanes merge writes; one lane module per byte
	genvar lane;
	generate
		for (lane = 0; lane < GAC_LANES; lane++) begin : g_lane
			gac_lane u_lane (
				.old_byte(read_word[lane*8 +: 8]),
				.new_byte(cfg_req.wdata[lane*8 +: 8]),
				.mask(write_mask[lane*8 +: 8]),
				.enable(cfg_req.valid & cfg_req.write & cfg_req.byte_en[lane]),
				.merged(merged_word[lane*8 +: 8])
			);
		end
	endgenerate

	// next state
	always_comb begin
		state_next = state_reg;
		// stored sized bits drop as soon as their size bit clears
		state_next.base_sized = sized_visible;
		state_next.done = cfg_req.valid;
		state_next.rdata = cfg_req.valid ? read_word : 32'h0000_0000;
		if (cfg_req.valid && cfg_req.write) begin
			unique case (cfg_req.addr)
				GAC_OFS_APERTURE_BASE: begin
					state_next.base_upper =
						merged_word[GAC_BASE_UPPER_LSB +: 4];
					// masked merge keeps read-only sized bits at zero
					state_next.base_sized =
						merged_word[GAC_BASE_SIZED_LSB +: 6];
				end
				GAC_OFS_SYSTEM_CONFIG: begin
					state_next.handshake_disable =
						merged_word[GAC_HANDSHAKE_BIT];
				end
				default: begin
					state_next.handshake_disable = state_reg.handshake_disable;
				end
			endcase
		end
	end

	// state register; reset values as the hardware defines them
	always_ff @(posedge clock) begin
		if (reset) begin
			state_reg.base_upper <= GAC_BASE_UPPER_RESET;
			state_reg.base_sized <= GAC_BASE_SIZED_RESET;
			state_reg.handshake_disable <=
				GAC_SYSTEM_CONFIG_RESET[GAC_HANDSHAKE_BIT];
			state_reg.rdata <= 32'h0000_0000;
			state_reg.done <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs come straight from the state flops
	assign cfg_rdata_reg = state_reg.rdata;
	assign cfg_done_reg = state_reg.done;
	assign aperture_base_address_reg = {state_reg.base_upper,
		state_reg.base_sized, GAC_APERTURE_LOW_FIXED};
	assign interrupt_write_handshake_disable_reg = state_reg.handshake_disable;

	// checks; all run on the bank clock and sleep through reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// reset values show on the first clock after release
	base_reset_value_a: assert property (
		$fell(reset) |->
		aperture_base_address_reg == GAC_APERTURE_BASE_RESET)
		else $error("base not at reset value after reset");

	handshake_reset_a: assert property (
		$fell(reset) |-> interrupt_write_handshake_disable_reg &&
		!cfg_done_reg && cfg_rdata_reg == 32'h0000_0000)
		else $error("handshake disable not set after reset");

	// every request gets exactly one answer pulse
	answer_pulse_a: assert property (
		cfg_req.valid |=> cfg_done_reg)
		else $error("request not answered");

	answer_idle_a: assert property (
		!cfg_req.valid |=> !cfg_done_reg && cfg_rdata_reg == 32'h0000_0000)
		else $error("answer without a request");

	// capability pointer is a constant and swallows writes
	cap_pointer_read_a: assert property (
		cfg_req.valid && cfg_req.addr == GAC_OFS_CAP_POINTER |=>
		cfg_done_reg &&
		cfg_rdata_reg == {24'h00_0000, GAC_CAP_POINTER_VALUE})
		else $error("capability pointer read wrong");

	cap_pointer_write_a: assert property (
		cfg_req.valid && cfg_req.write &&
		cfg_req.addr == GAC_OFS_CAP_POINTER |=>
		$stable(aperture_base_address_reg[GAC_BASE_UPPER_LSB +: 4]) &&
		$stable(interrupt_write_handshake_disable_reg))
		else $error("pointer write changed another register");

	// reserved low bits read back fixed
	base_low_fixed_a: assert property (
		cfg_req.valid && cfg_req.addr == GAC_OFS_APERTURE_BASE |=>
		cfg_rdata_reg[GAC_BASE_SIZED_LSB-1:0] ==
		GAC_APERTURE_LOW_FIXED)
		else $error("reserved base bits changed");

	// sized bits follow the size control, on reads and writes
	sized_bits_gated_a: assert property (
		(aperture_base_address_reg[GAC_BASE_SIZED_LSB +: 6] &
		~$past(aperture_size_control)) == 6'h00)
		else $error("sized base bit set while size bit clear");

	base_read_sized_a: assert property (
		cfg_req.valid && cfg_req.addr == GAC_OFS_APERTURE_BASE |=>
		cfg_rdata_reg[GAC_BASE_SIZED_LSB +: 6] ==
		($past(aperture_base_address_reg[GAC_BASE_SIZED_LSB +: 6]) &
		$past(aperture_size_control)))
		else $error("sized base bits read wrong");

	sized_write_a: assert property (
		cfg_req.valid && cfg_req.write &&
		cfg_req.addr == GAC_OFS_APERTURE_BASE &&
		cfg_req.byte_en[3] && cfg_req.byte_en[2] |=>
		aperture_base_address_reg[GAC_BASE_SIZED_LSB +: 6] ==
		($past(cfg_req.wdata[GAC_BASE_SIZED_LSB +: 6]) &
		$past(aperture_size_control)))
		else $error("sized base bits not written");

	sized_clear_now_a: assert property (
		cfg_req.valid && !cfg_req.write &&
		cfg_req.addr == GAC_OFS_APERTURE_BASE &&
		aperture_size_control == 6'h00 |=>
		cfg_rdata_reg[GAC_BASE_SIZED_LSB +: 6] == 6'h00)
		else $error("sized bits visible with size zero");

	// upper base bits are plain storage
	upper_write_a: assert property (
		cfg_req.valid && cfg_req.write &&
		cfg_req.addr == GAC_OFS_APERTURE_BASE && cfg_req.byte_en[3] |=>
		aperture_base_address_reg[GAC_BASE_UPPER_LSB +: 4] ==
		$past(cfg_req.wdata[GAC_BASE_UPPER_LSB +: 4]))
		else $error("upper base bits not written");

	upper_hold_a: assert property (
		!(cfg_req.valid && cfg_req.write &&
		cfg_req.addr == GAC_OFS_APERTURE_BASE && cfg_req.byte_en[3]) |=>
		$stable(aperture_base_address_reg[GAC_BASE_UPPER_LSB +: 4]))
		else $error("upper base bits changed without a write");

	// handshake disable bit is plain storage in byte lane one
	handshake_write_a: assert property (
		cfg_req.valid && cfg_req.write &&
		cfg_req.addr == GAC_OFS_SYSTEM_CONFIG && cfg_req.byte_en[1] |=>
		interrupt_write_handshake_disable_reg ==
		$past(cfg_req.wdata[GAC_HANDSHAKE_BIT]))
		else $error("handshake disable not written");

	handshake_hold_a: assert property (
		!(cfg_req.valid && cfg_req.write &&
		cfg_req.addr == GAC_OFS_SYSTEM_CONFIG && cfg_req.byte_en[1]) |=>
		$stable(interrupt_write_handshake_disable_reg))
		else $error("handshake disable changed without a write");

	// read data show the value from before a same-cycle write
	config_read_a: assert property (
		cfg_req.valid && cfg_req.addr == GAC_OFS_SYSTEM_CONFIG |=>
		cfg_done_reg && cfg_rdata_reg == {16'h0000,
		$past(interrupt_write_handshake_disable_reg), 15'h0000})
		else $error("config register read wrong");
endmodule

// ---- core/gac_pkg.sv ----
// Purpose: shared constants and types for the aperture config registers
// Assumes: dword-aligned configuration accesses with byte enables
// Notes: offsets are byte offsets of the dword that holds the register
package gac_pkg;
	// register offsets
	localparam logic [7:0] GAC_OFS_APERTURE_BASE = 8'h10;
	localparam logic [7:0] GAC_OFS_CAP_POINTER = 8'h34;
	localparam logic [7:0] GAC_OFS_SYSTEM_CONFIG = 8'h50;
	// reset and fixed values
	localparam logic [31:0] GAC_APERTURE_BASE_RESET = 32'h0000_0008;
	localparam logic [21:0] GAC_APERTURE_LOW_FIXED = 22'h00_0008;
	localparam logic [7:0] GAC_CAP_POINTER_VALUE = 8'ha0;
	localparam logic [15:0] GAC_SYSTEM_CONFIG_RESET = 16'h8000;
	localparam logic [3:0] GAC_BASE_UPPER_RESET = 4'h0;
	localparam logic [5:0] GAC_BASE_SIZED_RESET = 6'h00;
	// field positions
	localparam int GAC_BASE_UPPER_LSB = 28;
	localparam int GAC_BASE_SIZED_LSB = 22;
	localparam int GAC_HANDSHAKE_BIT = 15;
	localparam int GAC_LANES = 4;
	// writable masks per register
	localparam logic [31:0] GAC_UPPER_WMASK = 32'hf000_0000;
	localparam logic [31:0] GAC_CONFIG_WMASK = 32'h0000_8000;

	// one configuration request
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} gac_req_t;

	// whole state of the register bank
	typedef struct packed {
		logic [3:0] base_upper;
		logic [5:0] base_sized;
		logic handshake_disable;
		logic [31:0] rdata;
		logic done;
	} gac_state_t;
endpackage

// ---- core/gac_lane.sv ----
// Purpose: merge one byte lane of a configuration write
// Assumes: mask marks bits that software may change
// Notes: purely combinational
`timescale 1ns/1ps
module gac_lane (
	// lane inputs
	input wire logic [7:0] old_byte,
	input wire logic [7:0] new_byte,
	input wire logic [7:0] mask,
	input wire logic enable,
	// merged lane
	output logic [7:0] merged
);
	logic [7:0] take;

	// only masked bits of an enabled lane follow the write data
	always_comb begin
		take = enable ? mask : 8'h00;
		merged = (old_byte & ~take) | (new_byte & take);
	end
endmodule

// ---- bench/gac_cfg_master.sv ----
// Purpose: configuration master model that drives the register bank
// Assumes: one request at a time, changed on the falling edge
// Notes: answer is sampled half a clock after the taking edge
`timescale 1ns/1ps
module gac_cfg_master
	import gac_pkg::*;
(
	// clock
	input wire logic clock,
	// answer from the bank
	input wire logic [31:0] cfg_rdata_reg,
	input wire logic cfg_done_reg,
	// request to the bank
	output gac_req_t cfg_req
);
	logic done_seen;
	logic [31:0] rd_val;
	initial cfg_req = '0;
	// released lines carry the inverse so a stale value never matches
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d);
		@(negedge clock);
		cfg_req = '{1'b1, wr, a, be, d};
		// the answer stands only in the cycle after the taking edge
		@(negedge clock);
		done_seen = cfg_done_reg;
		rd_val = cfg_rdata_reg;
		cfg_req = '{1'b0, ~wr, ~a, ~be, ~d};
	endtask
endmodule

// ---- bench/gac_regs_tb.sv ----
// Purpose: self-checking bench for the aperture config registers
// Assumes: size control is driven by the bench on the falling edge
// Notes: newly enabled sized bits are written before they are read
`timescale 1ns/1ps
module gac_regs_tb import gac_pkg::*;;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [5:0] size = 6'h00;
	gac_req_t req;
	logic [31:0] rdata, base;
	logic done, hs_off;
	int miscompares = 0, check_count = 0, cycles = 0;
	// 50 ns clock
	initial begin
		forever #25 clock = ~clock;
	end
	gac_regs gac_regs_inst (.clock(clock), .reset(reset), .cfg_req(req),
		.cfg_rdata_reg(rdata), .cfg_done_reg(done),
		.aperture_size_control(size), .aperture_base_address_reg(base),
		.interrupt_write_handshake_disable_reg(hs_off));
	gac_cfg_master gac_cfg_master_inst (.clock(clock), .cfg_req(req),
		.cfg_rdata_reg(rdata), .cfg_done_reg(done));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// every access must be answered with a done pulse
	task automatic wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		gac_cfg_master_inst.access(1'b1, a, be, d);
		chk({31'h0, gac_cfg_master_inst.done_seen}, 32'h1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		gac_cfg_master_inst.access(1'b0, a, 4'hf, 32'h0);
		chk({31'h0, gac_cfg_master_inst.done_seen}, 32'h1);
		chk(gac_cfg_master_inst.rd_val, exp);
	endtask
	task automatic close_out();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// the run needs about 90 cycles, so 3000 means a hang
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(negedge clock);
		reset = 1'b0;
		rd(GAC_OFS_APERTURE_BASE, 32'h0000_0008);
		rd(GAC_OFS_CAP_POINTER, 32'h0000_00a0);
		rd(GAC_OFS_SYSTEM_CONFIG, 32'h0000_8000);
		chk({31'h0, hs_off}, 32'h1);
		rd(8'h20, 32'h0);
		wr(GAC_OFS_APERTURE_BASE, 4'hf, 32'hffff_ffff);
		rd(GAC_OFS_APERTURE_BASE, 32'hf000_0008);
		wr(GAC_OFS_CAP_POINTER, 4'hf, 32'h0);
		rd(GAC_OFS_CAP_POINTER, 32'h0000_00a0);
		// one size bit at a time; the others fall back to zero
		for (int i = 0; i < 6; i++) begin
			size = 6'h01 << i;
			wr(GAC_OFS_APERTURE_BASE, 4'hf, 32'hffff_ffff);
			rd(GAC_OFS_APERTURE_BASE,
				32'hf000_0008 | (32'h1 << (22 + i)));
		end
		size = 6'h3f;
		wr(GAC_OFS_APERTURE_BASE, 4'hf, 32'hffff_ffff);
		rd(GAC_OFS_APERTURE_BASE, 32'hffc0_0008);
		chk(base, 32'hffc0_0008);
		// top lane only: bits 23:22 must survive
		wr(GAC_OFS_APERTURE_BASE, 4'h8, 32'h0);
		rd(GAC_OFS_APERTURE_BASE, 32'h00c0_0008);
		size = 6'h00;
		rd(GAC_OFS_APERTURE_BASE, 32'h0000_0008);
		wr(GAC_OFS_SYSTEM_CONFIG, 4'h2, 32'h0);
		rd(GAC_OFS_SYSTEM_CONFIG, 32'h0);
		chk({31'h0, hs_off}, 32'h0);
		wr(GAC_OFS_SYSTEM_CONFIG, 4'hd, 32'hffff_ffff);
		rd(GAC_OFS_SYSTEM_CONFIG, 32'h0);
		wr(GAC_OFS_SYSTEM_CONFIG, 4'hf, 32'hffff_ffff);
		rd(GAC_OFS_SYSTEM_CONFIG, 32'h0000_8000);
		// a reset in mid-run must bring back every reset value
		wr(GAC_OFS_APERTURE_BASE, 4'hf, 32'hffff_ffff);
		wr(GAC_OFS_SYSTEM_CONFIG, 4'hf, 32'h0);
		reset = 1'b1;
		repeat (2) @(negedge clock);
		reset = 1'b0;
		rd(GAC_OFS_APERTURE_BASE, 32'h0000_0008);
		rd(GAC_OFS_SYSTEM_CONFIG, 32'h0000_8000);
		chk({31'h0, hs_off}, 32'h1);
		close_out();
	end
endmodule
